// ==== verilog/nfh_host.sv ====
// host sequencer: turns one command request into the flash bus cycle train
`default_nettype none
module nfh_host
  import nfh_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // mode: high selects byte addressing
  input  wire logic              byte_mode,
  // command request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire nfh_req_s          req,
  // completion
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_refused,
  // flash pins
  input  wire logic [DATA_W-1:0] dq_i,
  output nfh_pins_s              pins
);
  typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT, HS_DONE} nfh_hs_e;
  typedef enum logic [1:0] {MD_ARRAY, MD_BYPASS, MD_ERASING, MD_SUSP} nfh_md_e;
  typedef struct packed {
    nfh_hs_e                 st;
    nfh_md_e                 md;
    logic                    in_auto;
    logic                    err;
    nfh_req_s                r;
    logic [2:0]              idx;
    logic [2:0]              n;
    logic [DATA_W-1:0]       rd;
    logic                    rvalid;
  } nfh_st_s;
  nfh_st_s s_q, s_d;
  nfh_cyc_s cyc;
  logic cyc_go, cyc_busy, cyc_done;
  logic [DATA_W-1:0] cyc_rd;
  logic [11:0] u1, u2;
  logic [ADDR_W-1:0] sect_base;
  logic [2:0] ncyc;
  logic legal;
  nfh_cycle u_cyc (
    .clk   (clk),
    .nrst  (nrst),
    .go    (cyc_go),
    .cyc   (cyc),
    .busy  (cyc_busy),
    .done  (cyc_done),
    .rdata (cyc_rd),
    .dq_i  (dq_i),
    .pins  (pins)
  );
  assign u1 = byte_mode ? UNL1_BYTE : UNL1_WORD;                   // [RULE1]
  assign u2 = byte_mode ? UNL2_BYTE : UNL2_WORD;
  // address lines 19:12 survive, one above the seven-line sector field; lower lines are zeroed
  assign sect_base = {s_q.r.addr[ADDR_W-1:SECT_LO], SECT_LO'(0)}; // [RULE16]
  function automatic nfh_cyc_s wr(input logic [11:0] a, input logic [7:0] d);
    nfh_cyc_s c;
    c.addr = {{(ADDR_W-12){1'b0}}, a};                             // [RULE4]
    c.data = {8'h00, d};                                           // [RULE3]
    c.rd = 1'b0;
    return c;
  endfunction
  // cycle count and legality per mode
  always_comb begin
    ncyc = 3'd1;
    legal = 1'b1;
    unique case (req.cmd)
      NFH_READ: begin
        ncyc = 3'd1;
        legal = (s_q.md != MD_ERASING);
      end
      NFH_RESET: ncyc = 3'd1;                                      // [RULE6]
      NFH_AUTO_MFR, NFH_AUTO_DEV, NFH_PROT_VFY: begin
        ncyc = 3'd4;
        legal = (s_q.md == MD_ARRAY || s_q.md == MD_SUSP);        // [RULE18]
      end
      NFH_CFI: legal = !byte_mode && (s_q.md == MD_ARRAY || s_q.in_auto); // [RULE9]
      NFH_PROG: begin
        ncyc = 3'd4;                                               // [RULE10]
        legal = (s_q.md == MD_ARRAY || s_q.md == MD_SUSP) && !s_q.in_auto;
      end
      NFH_BYP_ENTER: begin
        ncyc = 3'd3;
        legal = (s_q.md == MD_ARRAY) && !s_q.in_auto;
      end
      NFH_BYP_PROG, NFH_BYP_EXIT: begin
        ncyc = 3'd2;
        legal = (s_q.md == MD_BYPASS);                             // [RULE13]
      end
      NFH_CHIP_ERASE, NFH_SECT_ERASE: begin
        ncyc = 3'd6;                                               // [RULE15]
        legal = (s_q.md == MD_ARRAY) && !s_q.in_auto;
      end
      NFH_SECT_ADD: legal = (s_q.md == MD_ERASING);                // [RULE20]
      NFH_SUSPEND: legal = (s_q.md == MD_ERASING);                 // [RULE17]
      NFH_RESUME: legal = (s_q.md == MD_SUSP) && !s_q.in_auto;     // [RULE19]
      NFH_SEC_ENTER: begin
        ncyc = req.sec_exit ? 3'd4 : 3'd3;                         // [RULE21]
        legal = (s_q.md == MD_ARRAY);
      end
    endcase
    // bypass accepts its program, its exit and F0 only
    if (s_q.md == MD_BYPASS && !(req.cmd inside {NFH_BYP_PROG, NFH_BYP_EXIT, NFH_RESET}))
      legal = 1'b0;                                                // [RULE23]
  end
  // cycle table indexed by position
  always_comb begin
    cyc = wr(u1, D_UNL1);
    if (s_q.idx == 3'd1) cyc = wr(u2, D_UNL2);
    if (s_q.idx == 3'd3) cyc = wr(u1, D_UNL1);
    if (s_q.idx == 3'd4) cyc = wr(u2, D_UNL2);
    unique case (s_q.r.cmd)
      NFH_READ: begin
        cyc.addr = s_q.r.addr;                                     // [RULE5]
        cyc.data = '0;
        cyc.rd = 1'b1;
      end
      NFH_RESET: cyc = wr(12'h000, D_RESET);
      NFH_AUTO_MFR, NFH_AUTO_DEV, NFH_PROT_VFY: begin
        if (s_q.idx == 3'd2) cyc = wr(u1, D_AUTO);
        if (s_q.idx == 3'd3) begin
          // fourth cycle is the identification read
          cyc = wr(OFS_MFR, D_ZERO);                               // [RULE2]
          cyc.rd = 1'b1;
          if (s_q.r.cmd == NFH_AUTO_DEV)
            cyc.addr[11:0] = byte_mode ? OFS_DEV_B : OFS_DEV_W;    // [RULE7]
          if (s_q.r.cmd == NFH_PROT_VFY)
            cyc.addr = sect_base | ADDR_W'(byte_mode ? OFS_PRT_B : OFS_PRT_W); // [RULE8]
        end
      end
      NFH_CFI: cyc = wr(CFI_ADDR, D_CFI);
      NFH_PROG: begin
        if (s_q.idx == 3'd2) cyc = wr(u1, D_PROG);
        if (s_q.idx == 3'd3) begin
          cyc.addr = s_q.r.addr;
          cyc.data = s_q.r.data;
        end
      end
      NFH_BYP_ENTER: if (s_q.idx == 3'd2) cyc = wr(u1, D_BYPASS);
      NFH_BYP_PROG: begin
        cyc = wr(12'h000, D_PROG);
        if (s_q.idx == 3'd1) begin
          cyc.addr = s_q.r.addr;
          cyc.data = s_q.r.data;
        end
      end
      NFH_BYP_EXIT: cyc = wr(12'h000, (s_q.idx == 3'd0) ? D_AUTO : D_ZERO); // [RULE14]
      NFH_CHIP_ERASE, NFH_SECT_ERASE: begin
        if (s_q.idx == 3'd2) cyc = wr(u1, D_ESETUP);
        if (s_q.idx == 3'd5) begin
          cyc = wr(u1, D_CHIP);
          if (s_q.r.cmd == NFH_SECT_ERASE) begin
            cyc.addr = sect_base;
            cyc.data = {8'h00, D_SECT};
          end
        end
      end
      NFH_SECT_ADD: begin
        cyc = wr(12'h000, D_SECT);
        cyc.addr = sect_base;
      end
      NFH_SUSPEND: cyc = wr(12'h000, D_SUSP);
      NFH_RESUME: cyc = wr(12'h000, D_SECT);
      NFH_SEC_ENTER: begin
        if (s_q.idx == 3'd2) cyc = wr(u1, s_q.r.sec_exit ? D_AUTO : D_SEC_IN);
        if (s_q.idx == 3'd3) cyc = wr(12'h000, D_ZERO);
      end
    endcase
  end
  assign cyc_go = (s_q.st == HS_ISSUE) && !cyc_busy;
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    unique case (s_q.st)
      HS_IDLE: if (req_valid) begin
        s_d.r = req;
        s_d.n = ncyc;
        s_d.idx = 3'd0;
        s_d.err = !legal;                                          // [RULE22]
        s_d.st = legal ? HS_ISSUE : HS_DONE;
      end
      HS_ISSUE: if (cyc_go) s_d.st = HS_WAIT;
      HS_WAIT: if (cyc_done) begin
        if (cyc.rd) s_d.rd = cyc_rd;
        if (s_q.idx == s_q.n - 3'd1) s_d.st = HS_DONE;
        else begin
          s_d.idx = s_q.idx + 3'd1;
          s_d.st = HS_ISSUE;
        end
      end
      HS_DONE: begin
        s_d.rvalid = 1'b1;
        s_d.st = HS_IDLE;
        if (!s_q.err) begin
          unique case (s_q.r.cmd)
            NFH_RESET: begin
              s_d.in_auto = 1'b0;
              if (s_q.md != MD_SUSP) s_d.md = MD_ARRAY;
            end
            NFH_AUTO_MFR, NFH_AUTO_DEV, NFH_PROT_VFY: s_d.in_auto = 1'b1;
            NFH_BYP_ENTER: s_d.md = MD_BYPASS;
            NFH_BYP_EXIT: s_d.md = MD_ARRAY;
            NFH_SECT_ERASE: s_d.md = MD_ERASING;
            NFH_SUSPEND: s_d.md = MD_SUSP;
            NFH_RESUME: s_d.md = MD_ERASING;
            default: s_d.md = s_q.md;
          endcase
          if (s_q.md == MD_BYPASS && s_q.r.cmd == NFH_RESET) s_d.md = MD_ARRAY;
        end
      end
    endcase
    // device ends erase on its own; host forgets once a reset is issued, except while suspended
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s_q <= '0;
    else s_q <= s_d;
  end
  assign req_ready   = (s_q.st == HS_IDLE);
  assign rsp_valid   = s_q.rvalid;
  assign rsp_data    = s_q.rd;
  assign rsp_refused = s_q.err;
endmodule
`default_nettype wire

// ==== verilog/nfh_pkg.sv ====
// constants and carriers for the nor flash host command sequencer
// Behaviour
// (RULE1) unlock AA/55 at 555/2AA word, AAA/555 byte
// (RULE2) all command cycles write, except ID read
// (RULE3) upper data byte driven zero on commands
// (RULE4) high address lines zero on command cycles
// (RULE5) array read is one bare read cycle
// (RULE6) F0 anywhere returns device to array read
// (RULE7) autoselect 90 then read X00/X01/X02
// (RULE8) protect verify read sector plus X02/X04
// (RULE9) CFI query 98 at 55, word only
// (RULE10) program: unlock, A0, then address and data
// (RULE11) program address stable before strobe falls
// (RULE12) program data stable through strobe rise
// (RULE13) bypass entry 20, then A0 plus data
// (RULE14) bypass exit 90 then 00, or F0
// (RULE15) erase: unlock 80 unlock then 10 or 30
// (RULE16) sector chosen by top seven address lines; host keeps the top eight, 19:12
// (RULE17) B0 suspend only during sector erase
// (RULE18) suspended: reads, programs, autoselect allowed
// (RULE19) 30 resume only while suspended
// (RULE20) extra sectors queued by one SA/30 write
// (RULE21) secured region entry 88, exit 90 00
// (RULE22) broken sequence abandons the partial command
// (RULE23) in bypass only bypass program and exit
`default_nettype none
package nfh_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [11:0] UNL1_WORD = 12'h555;
  localparam logic [11:0] UNL2_WORD = 12'h2AA;
  localparam logic [11:0] UNL1_BYTE = 12'hAAA;
  localparam logic [11:0] UNL2_BYTE = 12'h555;
  localparam logic [11:0] CFI_ADDR  = 12'h055;
  localparam logic [11:0] OFS_MFR   = 12'h000;
  localparam logic [11:0] OFS_DEV_W = 12'h001;
  localparam logic [11:0] OFS_DEV_B = 12'h002;
  localparam logic [11:0] OFS_PRT_W = 12'h002;
  localparam logic [11:0] OFS_PRT_B = 12'h004;
  localparam logic [7:0] D_UNL1   = 8'hAA;
  localparam logic [7:0] D_UNL2   = 8'h55;
  localparam logic [7:0] D_RESET  = 8'hF0;
  localparam logic [7:0] D_AUTO   = 8'h90;
  localparam logic [7:0] D_SEC_IN = 8'h88;
  localparam logic [7:0] D_ZERO   = 8'h00;
  localparam logic [7:0] D_CFI    = 8'h98;
  localparam logic [7:0] D_PROG   = 8'hA0;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_ESETUP = 8'h80;
  localparam logic [7:0] D_CHIP   = 8'h10;
  localparam logic [7:0] D_SECT   = 8'h30;
  localparam logic [7:0] D_SUSP   = 8'hB0;
  localparam int SECT_LO = 12;
  localparam int SECT_W  = 7;
  localparam int T_SETUP_NS  = 50;
  localparam int T_PULSE_NS  = 100;
  localparam int T_HOLD_NS   = 50;
  localparam int CLK_NS      = 50;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC  = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [3:0] {
    NFH_READ, NFH_RESET, NFH_AUTO_MFR, NFH_AUTO_DEV, NFH_PROT_VFY, NFH_CFI,
    NFH_PROG, NFH_BYP_ENTER, NFH_BYP_PROG, NFH_BYP_EXIT, NFH_CHIP_ERASE,
    NFH_SECT_ERASE, NFH_SECT_ADD, NFH_SUSPEND, NFH_RESUME, NFH_SEC_ENTER
  } nfh_cmd_e;
  typedef struct packed {
    nfh_cmd_e              cmd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
    logic                  sec_exit;
  } nfh_req_s;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe_n;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
  } nfh_pins_s;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rd;
  } nfh_cyc_s;
endpackage
`default_nettype wire

// ==== verilog/nfh_cycle.sv ====
// one asynchronous bus cycle on the flash pins, write or read
`default_nettype none
module nfh_cycle
  import nfh_pkg::*;
#(
  parameter int SETUP = SETUP_CYC,
  parameter int PULSE = PULSE_CYC,
  parameter int HOLD  = HOLD_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // cycle request
  input  wire logic              go,
  input  wire nfh_cyc_s          cyc,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  // flash pins
  input  wire logic [DATA_W-1:0] dq_i,
  output nfh_pins_s              pins
);
  // phase counts are at least one and at most 255, so each eight bit counter starts at count minus one, which may be zero
  if (SETUP < 1 || PULSE < 1 || HOLD < 1 || SETUP > 255 || PULSE > 255 || HOLD > 255) begin
    $error("nfh_cycle: phase counts out of range");
  end
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} nfh_cy_e;
  typedef struct packed {
    nfh_cy_e           st;
    logic [7:0]        cnt;
    nfh_cyc_s          c;
    logic [DATA_W-1:0] rd;
    logic              done;
  } nfh_cy_s;
  nfh_cy_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      CY_IDLE: if (go) begin
        s_d.c = cyc;
        s_d.cnt = 8'(SETUP - 1);
        s_d.st = CY_SETUP;
      end
      CY_SETUP: if (s_q.cnt == 8'h00) begin
        s_d.cnt = 8'(PULSE - 1);
        s_d.st = CY_PULSE;
      end else s_d.cnt = s_q.cnt - 8'h01;
      CY_PULSE: if (s_q.cnt == 8'h00) begin
        if (s_q.c.rd) s_d.rd = dq_i;
        s_d.cnt = 8'(HOLD - 1);
        s_d.st = CY_HOLD;
      end else s_d.cnt = s_q.cnt - 8'h01;
      CY_HOLD: if (s_q.cnt == 8'h00) begin
        s_d.done = 1'b1;
        s_d.st = CY_IDLE;
      end else s_d.cnt = s_q.cnt - 8'h01;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s_q <= '0;
    else s_q <= s_d;
  end
  // address set up before strobe falls, data held past its rise
  always_comb begin
    pins.addr    = s_q.c.addr;                                     // [RULE11]
    pins.dq_o    = s_q.c.data;                                     // [RULE12]
    pins.ce_n    = (s_q.st == CY_IDLE);
    pins.we_n    = !(s_q.st == CY_PULSE && !s_q.c.rd);
    pins.oe_n    = !(s_q.c.rd && s_q.st != CY_IDLE);
    pins.dq_oe_n = s_q.c.rd || s_q.st == CY_IDLE;
  end
  assign busy  = (s_q.st != CY_IDLE);
  assign done  = s_q.done;
  assign rdata = s_q.rd;
endmodule
`default_nettype wire

// ==== sim/nfh_host_props.sv ====
// bus cycle checker for the nor flash host sequencer
`default_nettype none
module nfh_host_props
  import nfh_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // request side
  input wire logic              byte_mode,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire nfh_req_s          req,
  // completion
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire logic              rsp_refused,
  // flash pins
  input wire logic [DATA_W-1:0] dq_i,
  input wire nfh_pins_s         pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_q;
  logic       dat_cyc;
  // checks wait for the third edge out of reset before judging strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  assign dat_cyc = req.cmd inside {NFH_PROG, NFH_BYP_PROG};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || up_q != 2'h3);
  chk_unlock_addr: assert property (
    $fell(pins.we_n) && pins.dq_o[7:0] == D_UNL1 && !dat_cyc
    |-> pins.addr == {8'h00, byte_mode ? UNL1_BYTE : UNL1_WORD}) else $error("unlock address");
  chk_upper_zero: assert property (
    !pins.we_n && !dat_cyc |-> pins.dq_o[15:8] == 8'h00) else $error("upper byte set");
  chk_strobe_pulse: assert property (
    $fell(pins.we_n) |-> !pins.ce_n && !pins.we_n ##1 !pins.we_n ##1 pins.we_n && !pins.ce_n)
    else $error("write pulse shape");
  chk_hold_addr: assert property (
    $fell(pins.we_n) |-> $stable(pins.addr) ##1 ($stable(pins.addr) && $stable(pins.dq_o)) [*2])
    else $error("address or data moved");
  chk_write_drive: assert property (
    !pins.we_n |-> !pins.dq_oe_n && pins.oe_n) else $error("write without drive");
  chk_read_release: assert property (
    !pins.oe_n |-> pins.dq_oe_n && pins.we_n && !pins.ce_n) else $error("read with drive");
  chk_refuse_quiet: assert property (
    rsp_valid && rsp_refused |-> pins.ce_n && $past(pins.ce_n) && $past(pins.ce_n, 2))
    else $error("refused command moved pins");
  chk_cfi_byte: assert property (
    req_valid && req_ready && req.cmd == NFH_CFI && byte_mode |-> ##2 rsp_valid && rsp_refused)
    else $error("byte query not refused");
  chk_rsp_bound: assert property (
    req_valid && req_ready |-> ##[2:60] rsp_valid) else $error("no completion");
endmodule
bind nfh_host nfh_host_props i_props (.clk(clk), .nrst(nrst), .byte_mode(byte_mode),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_refused(rsp_refused), .dq_i(dq_i), .pins(pins));
`default_nettype wire

// ==== sim/nfh_flash_model.sv ====
// behavioural nor flash device answering the host pins
`default_nettype none
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter logic [15:0] MFR_ID    = 16'h00C3, // arbitrary value
  parameter logic [15:0] DEV_ID    = 16'h1E77, // arbitrary value
  parameter logic [6:0]  PROT_SECT = 7'h05
) (
  // clock only paces the read bus
  input wire logic              clk,
  input wire logic              byte_mode,
  input wire nfh_pins_s         pins,
  output logic [DATA_W-1:0]     dq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] a_q;
  logic [7:0]        d;
  logic [11:0]       u1;
  logic [11:0]       u2;
  logic [11:0]       ofs;
  int                step = 0;
  int                mode = 0; // 0 array, 1 autoselect, 2 bypass, 3 query
  initial dq_i = 16'h0000;
  assign u1 = byte_mode ? UNL1_BYTE : UNL1_WORD;
  assign u2 = byte_mode ? UNL2_BYTE : UNL2_WORD;
  always @(negedge pins.we_n) a_q = pins.addr;
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    d = pins.dq_o[7:0];
    if (step == 9) begin
      mem[a_q] = pins.dq_o;
      step = 0;
    end else if (d == D_RESET) begin
      mode = 0;
      step = 0;
    end else if (mode == 2) begin
      if (step == 8 && d == D_ZERO) mode = 0;
      step = (d == D_PROG) ? 9 : (d == D_AUTO) ? 8 : 0;
    end else if (step == 0 && d == D_CFI && a_q[11:0] == CFI_ADDR && !byte_mode) mode = 3;
    else if (d == D_UNL1 && a_q[11:0] == u1 && step inside {0, 3}) step = step + 1;
    else if (d == D_UNL2 && a_q[11:0] == u2 && step inside {1, 4}) step = step + 1;
    else if (step == 2 && a_q[11:0] == u1) begin
      step = (d == D_PROG) ? 9 : (d == D_ESETUP) ? 3 : 0;
      if (d == D_AUTO) mode = 1;
      if (d == D_BYPASS) mode = 2;
    end else begin
      if (step == 5 && d == D_CHIP) mem.delete();
      if (d == D_ZERO) mode = 0;
      step = 0;
    end
  end
  // released bus keeps changing so a stale sample cannot pass
  always @(negedge clk) begin
    ofs = pins.addr[11:0];
    if (pins.ce_n || pins.oe_n) dq_i <= ~dq_i;
    else if (mode == 1 && ofs == OFS_MFR) dq_i <= MFR_ID;
    else if (mode == 1 && ofs == (byte_mode ? OFS_DEV_B : OFS_DEV_W)) dq_i <= DEV_ID;
    else if (mode == 1) dq_i <= {15'h0, pins.addr[SECT_LO +: SECT_W] == PROT_SECT};
    else dq_i <= mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
  end
endmodule
`default_nettype wire

// ==== sim/test_nfh_host.sv ====
// testbench for the nor flash host sequencer
`default_nettype none
module test_nfh_host
  import nfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MFR  = 16'h00C3;
  localparam logic [15:0] DEV  = 16'h1E77;
  localparam logic [19:0] PADR = 20'h01234;
  localparam logic [19:0] PSEC = 20'h05000;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              byte_mode = 1'b0;
  logic              req_valid = 1'b0;
  nfh_req_s          req = '0;
  logic              req_ready;
  logic              rsp_valid;
  logic              rsp_refused;
  logic [DATA_W-1:0] rsp_data;
  logic [DATA_W-1:0] dq_i;
  nfh_pins_s         pins;
  int                failures = 0;
  int                compares = 0;
  always #25 clk = ~clk;
  nfh_host i_dut (.clk(clk), .nrst(nrst), .byte_mode(byte_mode), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_refused(rsp_refused), .dq_i(dq_i), .pins(pins));
  nfh_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT_SECT(PSEC[18:12])) i_flash (
    .clk(clk), .byte_mode(byte_mode), .pins(pins), .dq_i(dq_i));
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t flag got %h exp %h", $time, got, exp);
    end
  endtask
  // one command, waits its completion and judges the refusal flag
  task automatic issue(input nfh_cmd_e c, input logic [19:0] a, input logic rf,
                       input logic [15:0] d = 16'h0000, input logic sx = 1'b0);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      failures++;
      tally_and_finish();
    end
    req = '{c, a, d, sx};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    if (n == 80) begin
      failures++;
      tally_and_finish();
    end
    cmp_flag(rsp_refused, rf);
  endtask
  task automatic t_program();
    for (int b = 0; b < 2; b++) begin
      byte_mode = b[0];
      issue(NFH_PROG, PADR + 20'(b), 1'b0, 16'h5A3C + 16'(b));
      issue(NFH_READ, PADR + 20'(b), 1'b0);
      cmp_data(rsp_data, 16'h5A3C + 16'(b));
    end
  endtask
  task automatic t_autosel();
    for (int b = 0; b < 2; b++) begin
      byte_mode = b[0];
      issue(NFH_AUTO_MFR, 20'h00000, 1'b0);
      cmp_data(rsp_data, MFR);
      issue(NFH_AUTO_DEV, 20'h00000, 1'b0);
      cmp_data(rsp_data, DEV);
      issue(NFH_PROT_VFY, PSEC, 1'b0);
      cmp_data(rsp_data, 16'h0001);
      issue(NFH_PROT_VFY, PSEC + 20'h01000, 1'b0);
      cmp_data(rsp_data, 16'h0000);
      issue(NFH_RESET, 20'h00000, 1'b0);
      issue(NFH_READ, PADR, 1'b0);
      cmp_data(rsp_data, 16'h5A3C);
    end
  endtask
  task automatic t_bypass();
    byte_mode = 1'b0;
    issue(NFH_BYP_PROG, PADR, 1'b1);
    issue(NFH_BYP_ENTER, 20'h00000, 1'b0);
    issue(NFH_READ, PADR, 1'b1);
    issue(NFH_AUTO_MFR, 20'h00000, 1'b1);
    issue(NFH_BYP_PROG, PADR + 20'h00010, 1'b0, 16'hC3E1);
    issue(NFH_BYP_EXIT, 20'h00000, 1'b0);
    issue(NFH_READ, PADR + 20'h00010, 1'b0);
    cmp_data(rsp_data, 16'hC3E1);
    issue(NFH_BYP_ENTER, 20'h00000, 1'b0);
    issue(NFH_RESET, 20'h00000, 1'b0);
    issue(NFH_READ, PADR, 1'b0);
    cmp_data(rsp_data, 16'h5A3C);
  endtask
  task automatic t_cfi();
    byte_mode = 1'b1;
    issue(NFH_CFI, 20'h00000, 1'b1);
    byte_mode = 1'b0;
    issue(NFH_CFI, 20'h00000, 1'b0);
    issue(NFH_RESET, 20'h00000, 1'b0);
  endtask
  task automatic t_erase();
    issue(NFH_SUSPEND, 20'h00000, 1'b1);
    issue(NFH_SECT_ADD, PSEC, 1'b1);
    issue(NFH_RESUME, 20'h00000, 1'b1);
    issue(NFH_SECT_ERASE, 20'h20000, 1'b0);
    issue(NFH_SECT_ADD, 20'h30000, 1'b0);
    issue(NFH_RESUME, 20'h00000, 1'b1);
    issue(NFH_SUSPEND, 20'h00000, 1'b0);
    issue(NFH_PROG, PADR + 20'h00020, 1'b0, 16'h0F1E);
    issue(NFH_READ, PADR + 20'h00020, 1'b0);
    cmp_data(rsp_data, 16'h0F1E);
    issue(NFH_RESUME, 20'h00000, 1'b0);
    issue(NFH_SUSPEND, 20'h00000, 1'b0);
    issue(NFH_AUTO_MFR, 20'h00000, 1'b0);
    cmp_data(rsp_data, MFR);
    issue(NFH_RESET, 20'h00000, 1'b0);
    // still suspended after leaving autoselect, so a new erase is refused
    issue(NFH_CHIP_ERASE, 20'h00000, 1'b1);
    issue(NFH_RESUME, 20'h00000, 1'b0);
    issue(NFH_RESET, 20'h00000, 1'b0);
    issue(NFH_CHIP_ERASE, 20'h00000, 1'b0);
    issue(NFH_SUSPEND, 20'h00000, 1'b1);
    issue(NFH_RESET, 20'h00000, 1'b0);
  endtask
  task automatic t_secured();
    issue(NFH_SEC_ENTER, 20'h00000, 1'b0);
    issue(NFH_SEC_ENTER, 20'h00000, 1'b0, 16'h0000, 1'b1);
    issue(NFH_READ, PADR, 1'b0);
    cmp_data(rsp_data, 16'hFFFF);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_program();
    t_autosel();
    t_bypass();
    t_cfi();
    t_erase();
    t_secured();
    tally_and_finish();
  end
endmodule
`default_nettype wire
